// file: rtl/ppio_cfg.svh
// Purpose: offsets, reset values and pin masks of the port pin block
// Assumes: 8-bit register port, byte offsets inside the I/O block
// Notes: definitions only
`ifndef PPIO_CFG_SVH
`define PPIO_CFG_SVH
`define PPIO_OFS_A_IN 8'h00
`define PPIO_OFS_B_IN 8'h01
`define PPIO_OFS_A_OUT 8'h04
`define PPIO_OFS_B_OUT 8'h05
`define PPIO_OFS_A_DIR 8'h06
`define PPIO_OFS_B_DIR 8'h07
`define PPIO_OFS_C_IN 8'h10
`define PPIO_OFS_D_IN 8'h11
`define PPIO_OFS_C_OUT 8'h12
`define PPIO_OFS_D_OUT 8'h13
`define PPIO_OFS_C_DIR 8'h14
`define PPIO_OFS_D_DIR 8'h15
`define PPIO_RST_VAL 8'h00
`define PPIO_MASK_FULL 8'hff
`define PPIO_MASK_C 8'h9c
`define PPIO_MASK_D 8'h06
`define PPIO_MASK_D_SMALL 8'h02
`endif

// file: rtl/ppio_pkg.sv
// Purpose: shared types of the port pin block
// Assumes: nothing
// Notes: constants live in ppio_cfg.svh
package ppio_pkg;
	typedef logic [7:0] ppio_byte_t;
	typedef enum logic [1:0] {
		PPIO_PKG_FULL = 2'b00,
		PPIO_PKG_SMALL = 2'b01
	} ppio_variant_t;
endpackage : ppio_pkg

// file: rtl/ppio_port_pins.sv
// Purpose: processor pin I/O and logic-array routing for ports A to D
// Assumes: single 40 MHz clock mclk, inputs synchronous to it
// Notes: small_pkg drops port A and pin D2
`timescale 1ns/1ps
`include "ppio_cfg.svh"

// Summary of operation
// - reading an input register returns present pin levels, one per bit
// - port C input bits 7,4,3,2 follow pins; others carry no meaning
// - port D input bits 2 and 1 follow pins; others undefined
// - output register bit 1 drives high, 0 drives low when enabled
// - output and direction registers reset to zero
// - direction bit 1 makes pin output, 0 makes it input
// - port C output and direction hold only bits 7,4,3,2
// - port D output and direction hold only bits 2,1; bit 2 absent small
// - port A omitted in the small package; B, C, D stay
// - ports A,B,C reach logic-array bus via input macrocells; D directly
// - A,B,C take output macrocells; D takes decode-array chip selects
// - a logic-array output pin ignores its output register bit
// - logic-array input pins stay readable; direction still drives
// - driver enable is logic-array enable OR direction bit
// - pins start as inputs unless logic-array enable is active
// - internal-node macrocells leave their pin free for other I/O
// - port A input sits at 00h, port B input at 01h
module ppio_port_pins #(
	parameter bit SMALL_PKG = 1'b0
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] port_a_in,
	input wire logic [7:0] port_b_in,
	input wire logic [7:0] port_c_in,
	input wire logic [7:0] port_d_in,
	output logic [7:0] port_a_out,
	output logic [7:0] port_b_out,
	output logic [7:0] port_c_out,
	output logic [7:0] port_d_out,
	output logic [7:0] port_a_oe,
	output logic [7:0] port_b_oe,
	output logic [7:0] port_c_oe,
	output logic [7:0] port_d_oe,
	input wire logic [7:0] gla_pin_sel_a,
	input wire logic [7:0] gla_pin_sel_b,
	input wire logic [7:0] gla_pin_sel_c,
	input wire logic [7:0] dla_pin_sel_d,
	input wire logic [7:0] gla_out_a,
	input wire logic [7:0] gla_out_b,
	input wire logic [7:0] gla_out_c,
	input wire logic [7:0] dla_cs_d,
	input wire logic [7:0] la_oe_a,
	input wire logic [7:0] la_oe_b,
	input wire logic [7:0] la_oe_c,
	input wire logic [7:0] la_oe_d,
	output logic [7:0] imc_bus_a,
	output logic [7:0] imc_bus_b,
	output logic [7:0] imc_bus_c,
	output logic [7:0] la_bus_d
);

	// ********************************************
	// masks per variant
	// ********************************************
	localparam logic [7:0] MASK_A = SMALL_PKG ? 8'h00 : `PPIO_MASK_FULL;
	localparam logic [7:0] MASK_B = `PPIO_MASK_FULL;
	localparam logic [7:0] MASK_C = `PPIO_MASK_C;
	localparam logic [7:0] MASK_D = SMALL_PKG ? `PPIO_MASK_D_SMALL : `PPIO_MASK_D;

	function automatic ppio_pkg::ppio_byte_t ppio_drive(
		input ppio_pkg::ppio_byte_t sel,
		input ppio_pkg::ppio_byte_t la_val,
		input ppio_pkg::ppio_byte_t reg_val,
		input ppio_pkg::ppio_byte_t mask
	);
		ppio_drive = ((sel & la_val) | (~sel & reg_val)) & mask;
	endfunction : ppio_drive

	function automatic ppio_pkg::ppio_byte_t ppio_enable(
		input ppio_pkg::ppio_byte_t la_en,
		input ppio_pkg::ppio_byte_t dir,
		input ppio_pkg::ppio_byte_t mask
	);
		ppio_enable = (la_en | dir) & mask;
	endfunction : ppio_enable

	// ********************************************
	// stored registers
	// ********************************************
	ppio_pkg::ppio_byte_t out_a, out_b, out_c, out_d;
	ppio_pkg::ppio_byte_t dir_a, dir_b, dir_c, dir_d;

	wire wr_out_a = reg_wr && (reg_addr == `PPIO_OFS_A_OUT);
	wire wr_out_b = reg_wr && (reg_addr == `PPIO_OFS_B_OUT);
	wire wr_out_c = reg_wr && (reg_addr == `PPIO_OFS_C_OUT);
	wire wr_out_d = reg_wr && (reg_addr == `PPIO_OFS_D_OUT);
	wire wr_dir_a = reg_wr && (reg_addr == `PPIO_OFS_A_DIR);
	wire wr_dir_b = reg_wr && (reg_addr == `PPIO_OFS_B_DIR);
	wire wr_dir_c = reg_wr && (reg_addr == `PPIO_OFS_C_DIR);
	wire wr_dir_d = reg_wr && (reg_addr == `PPIO_OFS_D_DIR);

	// unimplemented bits never store, so they read back zero
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			out_a <= `PPIO_RST_VAL;
			out_b <= `PPIO_RST_VAL;
			out_c <= `PPIO_RST_VAL;
			out_d <= `PPIO_RST_VAL;
			dir_a <= `PPIO_RST_VAL;
			dir_b <= `PPIO_RST_VAL;
			dir_c <= `PPIO_RST_VAL;
			dir_d <= `PPIO_RST_VAL;
		end else begin
			if (wr_out_a) out_a <= reg_wdata & MASK_A;
			if (wr_out_b) out_b <= reg_wdata & MASK_B;
			if (wr_out_c) out_c <= reg_wdata & MASK_C;
			if (wr_out_d) out_d <= reg_wdata & MASK_D;
			if (wr_dir_a) dir_a <= reg_wdata & MASK_A;
			if (wr_dir_b) dir_b <= reg_wdata & MASK_B;
			if (wr_dir_c) dir_c <= reg_wdata & MASK_C;
			if (wr_dir_d) dir_d <= reg_wdata & MASK_D;
		end
	end

	// ********************************************
	// read mux
	// ********************************************
	// unguaranteed input bits read as zero, a legal choice
	wire [7:0] next_reg_rdata =
		(reg_addr == `PPIO_OFS_A_IN) ? (port_a_in & MASK_A) :
		(reg_addr == `PPIO_OFS_B_IN) ? (port_b_in & MASK_B) :
		(reg_addr == `PPIO_OFS_C_IN) ? (port_c_in & MASK_C) :
		(reg_addr == `PPIO_OFS_D_IN) ? (port_d_in & MASK_D) :
		(reg_addr == `PPIO_OFS_A_OUT) ? out_a :
		(reg_addr == `PPIO_OFS_B_OUT) ? out_b :
		(reg_addr == `PPIO_OFS_C_OUT) ? out_c :
		(reg_addr == `PPIO_OFS_D_OUT) ? out_d :
		(reg_addr == `PPIO_OFS_A_DIR) ? dir_a :
		(reg_addr == `PPIO_OFS_B_DIR) ? dir_b :
		(reg_addr == `PPIO_OFS_C_DIR) ? dir_c :
		(reg_addr == `PPIO_OFS_D_DIR) ? dir_d : 8'h00;

	// ********************************************
	// pin drive and logic-array routing
	// ********************************************
	wire [7:0] next_a_out = ppio_drive(gla_pin_sel_a, gla_out_a, out_a, MASK_A);
	wire [7:0] next_b_out = ppio_drive(gla_pin_sel_b, gla_out_b, out_b, MASK_B);
	wire [7:0] next_c_out = ppio_drive(gla_pin_sel_c, gla_out_c, out_c, MASK_C);
	wire [7:0] next_d_out = ppio_drive(dla_pin_sel_d, dla_cs_d, out_d, MASK_D);
	wire [7:0] next_a_oe = ppio_enable(la_oe_a, dir_a, MASK_A);
	wire [7:0] next_b_oe = ppio_enable(la_oe_b, dir_b, MASK_B);
	wire [7:0] next_c_oe = ppio_enable(la_oe_c, dir_c, MASK_C);
	wire [7:0] next_d_oe = ppio_enable(la_oe_d, dir_d, MASK_D);

	// registered outputs cost a cycle of latency on pins and logic-array inputs
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
			port_a_out <= 8'h00;
			port_b_out <= 8'h00;
			port_c_out <= 8'h00;
			port_d_out <= 8'h00;
			port_a_oe <= 8'h00;
			port_b_oe <= 8'h00;
			port_c_oe <= 8'h00;
			port_d_oe <= 8'h00;
			imc_bus_a <= 8'h00;
			imc_bus_b <= 8'h00;
			imc_bus_c <= 8'h00;
			la_bus_d <= 8'h00;
		end else begin
			if (reg_rd) reg_rdata <= next_reg_rdata;
			port_a_out <= next_a_out;
			port_b_out <= next_b_out;
			port_c_out <= next_c_out;
			port_d_out <= next_d_out;
			port_a_oe <= next_a_oe;
			port_b_oe <= next_b_oe;
			port_c_oe <= next_c_oe;
			port_d_oe <= next_d_oe;
			imc_bus_a <= port_a_in & MASK_A;
			imc_bus_b <= port_b_in & MASK_B;
			imc_bus_c <= port_c_in & MASK_C;
			la_bus_d <= port_d_in & MASK_D;
		end
	end

	// ********************************************
	// checks
	// ********************************************
	a_dir_enables_pin: assert property (@(posedge mclk) disable iff (!arst_n)
		wr_dir_b ##1 1'b1 |=> (port_b_oe == ($past(reg_wdata, 2) | $past(la_oe_b))))
		else $error("port b enable not direction or la enable");
	a_out_value_drive: assert property (@(posedge mclk) disable iff (!arst_n)
		(wr_out_b && gla_pin_sel_b == 8'h00) |=> ##1 (port_b_out == $past(reg_wdata, 2)))
		else $error("port b pin value not written value");
	a_la_out_wins: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (port_c_out == ($past(gla_pin_sel_c & gla_out_c | ~gla_pin_sel_c & out_c) & MASK_C)))
		else $error("port c logic-array select ignored");
	a_c_mask_held: assert property (@(posedge mclk) disable iff (!arst_n)
		((out_c | dir_c) & ~MASK_C) == 8'h00)
		else $error("port c unimplemented bit stored");
	a_d_mask_held: assert property (@(posedge mclk) disable iff (!arst_n)
		(port_d_oe & ~MASK_D) == 8'h00)
		else $error("port d unimplemented pin enabled");
	a_a_absent_small: assert property (@(posedge mclk) disable iff (!arst_n)
		SMALL_PKG |-> (port_a_oe == 8'h00 && out_a == 8'h00))
		else $error("port a active in small package");
	a_read_pin_c: assert property (@(posedge mclk) disable iff (!arst_n)
		(reg_rd && reg_addr == `PPIO_OFS_C_IN) |=> ((reg_rdata & MASK_C) == ($past(port_c_in) & MASK_C)))
		else $error("port c read not pin level");
	a_read_back_dir: assert property (@(posedge mclk) disable iff (!arst_n)
		(wr_dir_d ##1 !wr_dir_d ##1 (reg_rd && reg_addr == `PPIO_OFS_D_DIR && !reg_wr))
		|=> (reg_rdata == ($past(reg_wdata, 3) & MASK_D)))
		else $error("port d direction read-back wrong");
	a_d_direct_bus: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (la_bus_d == ($past(port_d_in) & MASK_D)))
		else $error("port d logic-array bus wrong");

	// ********************************************
	// per-port pin and register checks
	// ********************************************
	a_dir_oe_a: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> ((port_a_oe & $past(dir_a)) == $past(dir_a)))
		else $error("port a direction bit left pin undriven");
	a_laen_oe_a: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> ((port_a_oe & $past(la_oe_a & MASK_A)) == $past(la_oe_a & MASK_A)))
		else $error("port a logic-array enable ignored");
	a_idle_hiz_a: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> ((port_a_oe & ~$past(la_oe_a | dir_a)) == 8'h00))
		else $error("port a pin driven without enable");
	a_reg_drive_a: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (((port_a_out ^ $past(out_a)) & ~$past(gla_pin_sel_a)) == 8'h00))
		else $error("port a pin value not register value");
	a_la_drive_a: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (((port_a_out ^ $past(gla_out_a)) & $past(gla_pin_sel_a) & MASK_A) == 8'h00))
		else $error("port a logic-array value not on pin");
	a_dir_oe_b: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> ((port_b_oe & $past(dir_b)) == $past(dir_b)))
		else $error("port b direction bit left pin undriven");
	a_laen_oe_b: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> ((port_b_oe & $past(la_oe_b & MASK_B)) == $past(la_oe_b & MASK_B)))
		else $error("port b logic-array enable ignored");
	a_idle_hiz_b: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> ((port_b_oe & ~$past(la_oe_b | dir_b)) == 8'h00))
		else $error("port b pin driven without enable");
	a_reg_drive_b: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (((port_b_out ^ $past(out_b)) & ~$past(gla_pin_sel_b)) == 8'h00))
		else $error("port b pin value not register value");
	a_la_drive_b: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (((port_b_out ^ $past(gla_out_b)) & $past(gla_pin_sel_b) & MASK_B) == 8'h00))
		else $error("port b logic-array value not on pin");
	a_dir_oe_c: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> ((port_c_oe & $past(dir_c)) == $past(dir_c)))
		else $error("port c direction bit left pin undriven");
	a_laen_oe_c: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> ((port_c_oe & $past(la_oe_c & MASK_C)) == $past(la_oe_c & MASK_C)))
		else $error("port c logic-array enable ignored");
	a_idle_hiz_c: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> ((port_c_oe & ~$past(la_oe_c | dir_c)) == 8'h00))
		else $error("port c pin driven without enable");
	a_reg_drive_c: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (((port_c_out ^ $past(out_c)) & ~$past(gla_pin_sel_c)) == 8'h00))
		else $error("port c pin value not register value");
	a_la_drive_c: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (((port_c_out ^ $past(gla_out_c)) & $past(gla_pin_sel_c) & MASK_C) == 8'h00))
		else $error("port c logic-array value not on pin");
	a_dir_oe_d: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> ((port_d_oe & $past(dir_d)) == $past(dir_d)))
		else $error("port d direction bit left pin undriven");
	a_laen_oe_d: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> ((port_d_oe & $past(la_oe_d & MASK_D)) == $past(la_oe_d & MASK_D)))
		else $error("port d logic-array enable ignored");
	a_idle_hiz_d: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> ((port_d_oe & ~$past(la_oe_d | dir_d)) == 8'h00))
		else $error("port d pin driven without enable");
	a_reg_drive_d: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (((port_d_out ^ $past(out_d)) & ~$past(dla_pin_sel_d)) == 8'h00))
		else $error("port d pin value not register value");
	a_cs_drive_d: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (((port_d_out ^ $past(dla_cs_d)) & $past(dla_pin_sel_d) & MASK_D) == 8'h00))
		else $error("port d chip select not on pin");
	a_imc_bus_a: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (imc_bus_a == ($past(port_a_in) & MASK_A)))
		else $error("port a input macrocell bus wrong");
	a_imc_bus_b: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (imc_bus_b == ($past(port_b_in) & MASK_B)))
		else $error("port b input macrocell bus wrong");
	a_imc_bus_c: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (imc_bus_c == ($past(port_c_in) & MASK_C)))
		else $error("port c input macrocell bus wrong");
	a_read_pin_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(reg_rd && reg_addr == `PPIO_OFS_A_IN) |=> ((reg_rdata & MASK_A) == ($past(port_a_in) & MASK_A)))
		else $error("port a read not pin level");
	a_read_pin_b: assert property (@(posedge mclk) disable iff (!arst_n)
		(reg_rd && reg_addr == `PPIO_OFS_B_IN) |=> ((reg_rdata & MASK_B) == ($past(port_b_in) & MASK_B)))
		else $error("port b read not pin level");
	a_read_pin_d: assert property (@(posedge mclk) disable iff (!arst_n)
		(reg_rd && reg_addr == `PPIO_OFS_D_IN) |=> ((reg_rdata & MASK_D) == ($past(port_d_in) & MASK_D)))
		else $error("port d read not pin level");
	a_read_out_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(reg_rd && reg_addr == `PPIO_OFS_A_OUT) |=> (reg_rdata == $past(out_a)))
		else $error("port a output read-back wrong");
	a_read_out_b: assert property (@(posedge mclk) disable iff (!arst_n)
		(reg_rd && reg_addr == `PPIO_OFS_B_OUT) |=> (reg_rdata == $past(out_b)))
		else $error("port b output read-back wrong");
	a_read_out_c: assert property (@(posedge mclk) disable iff (!arst_n)
		(reg_rd && reg_addr == `PPIO_OFS_C_OUT) |=> (reg_rdata == $past(out_c)))
		else $error("port c output read-back wrong");
	a_read_out_d: assert property (@(posedge mclk) disable iff (!arst_n)
		(reg_rd && reg_addr == `PPIO_OFS_D_OUT) |=> (reg_rdata == $past(out_d)))
		else $error("port d output read-back wrong");
	a_read_dir_a: assert property (@(posedge mclk) disable iff (!arst_n)
		(reg_rd && reg_addr == `PPIO_OFS_A_DIR) |=> (reg_rdata == $past(dir_a)))
		else $error("port a direction read-back wrong");
	a_read_dir_b: assert property (@(posedge mclk) disable iff (!arst_n)
		(reg_rd && reg_addr == `PPIO_OFS_B_DIR) |=> (reg_rdata == $past(dir_b)))
		else $error("port b direction read-back wrong");
	a_read_dir_c: assert property (@(posedge mclk) disable iff (!arst_n)
		(reg_rd && reg_addr == `PPIO_OFS_C_DIR) |=> (reg_rdata == $past(dir_c)))
		else $error("port c direction read-back wrong");
	a_write_out_a: assert property (@(posedge mclk) disable iff (!arst_n)
		wr_out_a |=> (out_a == ($past(reg_wdata) & MASK_A)))
		else $error("port a output write lost");
	a_write_out_b: assert property (@(posedge mclk) disable iff (!arst_n)
		wr_out_b |=> (out_b == ($past(reg_wdata) & MASK_B)))
		else $error("port b output write lost");
	a_write_out_c: assert property (@(posedge mclk) disable iff (!arst_n)
		wr_out_c |=> (out_c == ($past(reg_wdata) & MASK_C)))
		else $error("port c output write lost");
	a_write_out_d: assert property (@(posedge mclk) disable iff (!arst_n)
		wr_out_d |=> (out_d == ($past(reg_wdata) & MASK_D)))
		else $error("port d output write lost");
	a_rdata_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (@(posedge mclk) disable iff (!arst_n)
		(reg_rd && reg_addr == 8'h20) |=> (reg_rdata == 8'h00))
		else $error("unmapped read not zero");
	a_in_write_ignored: assert property (@(posedge mclk) disable iff (!arst_n)
		(reg_wr && reg_addr == `PPIO_OFS_C_IN) |=> ($stable(out_c) && $stable(dir_c)))
		else $error("write to input register stored");

endmodule : ppio_port_pins

// file: sim/ppio_pin_model.sv
// Purpose: external circuitry on the port pins
// Assumes: one model per 8-pin port
// Notes: undriven pins show the level the bench gives
`timescale 1ns/1ps
// ****************************************
// pin level resolution
// ****************************************
module ppio_pin_model (
	input wire logic [7:0] drv_val,
	input wire logic [7:0] drv_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pin_level
);
	// per-bit resolve, so mixed in/out ports read back correctly
	assign pin_level = (drv_en & drv_val) | (~drv_en & ext_val);
endmodule : ppio_pin_model

// file: sim/tb_top.sv
// Purpose: self-checking bench for the port pin block
// Assumes: both package variants, inputs driven on falling mclk
// Notes: read data compared from a queue by a watcher process
`timescale 1ns/1ps
`include "ppio_cfg.svh"
module tb_top;
	// ****************************************
	// signals
	// ****************************************
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, eoe, eout, lvl;
	logic reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
	logic [7:0] sel[4], lav[4], lao[4], ext[4], dir[4], outr[4], expq[$];
	wire logic [7:0] po[4], poe[4], pin[4], bus[4];
	wire logic [7:0] po_s[4], poe_s[4], bus_s[4], rdata_s;
	logic [7:0] msk[4] = '{`PPIO_MASK_FULL, `PPIO_MASK_FULL, `PPIO_MASK_C, `PPIO_MASK_D};
	logic [7:0] ofs_in[4] = '{`PPIO_OFS_A_IN, `PPIO_OFS_B_IN, `PPIO_OFS_C_IN, `PPIO_OFS_D_IN};
	logic [7:0] ofs_out[4] = '{`PPIO_OFS_A_OUT, `PPIO_OFS_B_OUT, `PPIO_OFS_C_OUT, `PPIO_OFS_D_OUT};
	logic [7:0] ofs_dir[4] = '{`PPIO_OFS_A_DIR, `PPIO_OFS_B_DIR, `PPIO_OFS_C_DIR, `PPIO_OFS_D_DIR};
	int error_cnt = 0, cmp_count = 0, cyc = 0, seed = 56480;
	initial forever #12.5 mclk = ~mclk;
	for (genvar p = 0; p < 4; p++) begin : g_pin
		ppio_pin_model i_ppio_pin_model (.drv_val(po[p]), .drv_en(poe[p]), .ext_val(ext[p]), .pin_level(pin[p]));
	end
	ppio_port_pins #(.SMALL_PKG(1'b0)) i_ppio_port_pins (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.port_a_in(pin[0]), .port_b_in(pin[1]), .port_c_in(pin[2]), .port_d_in(pin[3]),
		.port_a_out(po[0]), .port_b_out(po[1]), .port_c_out(po[2]), .port_d_out(po[3]),
		.port_a_oe(poe[0]), .port_b_oe(poe[1]), .port_c_oe(poe[2]), .port_d_oe(poe[3]),
		.gla_pin_sel_a(sel[0]), .gla_pin_sel_b(sel[1]), .gla_pin_sel_c(sel[2]), .dla_pin_sel_d(sel[3]),
		.gla_out_a(lav[0]), .gla_out_b(lav[1]), .gla_out_c(lav[2]), .dla_cs_d(lav[3]),
		.la_oe_a(lao[0]), .la_oe_b(lao[1]), .la_oe_c(lao[2]), .la_oe_d(lao[3]),
		.imc_bus_a(bus[0]), .imc_bus_b(bus[1]), .imc_bus_c(bus[2]), .la_bus_d(bus[3]));
	// small variant shares stimulus; its pins are not fed back
	if (1) begin : g_small
		ppio_port_pins #(.SMALL_PKG(1'b1)) i_ppio_port_pins (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
			.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdata_s),
			.port_a_in(pin[0]), .port_b_in(pin[1]), .port_c_in(pin[2]), .port_d_in(pin[3]),
			.port_a_out(po_s[0]), .port_b_out(po_s[1]), .port_c_out(po_s[2]), .port_d_out(po_s[3]),
			.port_a_oe(poe_s[0]), .port_b_oe(poe_s[1]), .port_c_oe(poe_s[2]), .port_d_oe(poe_s[3]),
			.gla_pin_sel_a(sel[0]), .gla_pin_sel_b(sel[1]), .gla_pin_sel_c(sel[2]), .dla_pin_sel_d(sel[3]),
			.gla_out_a(lav[0]), .gla_out_b(lav[1]), .gla_out_c(lav[2]), .dla_cs_d(lav[3]),
			.la_oe_a(lao[0]), .la_oe_b(lao[1]), .la_oe_c(lao[2]), .la_oe_d(lao[3]),
			.imc_bus_a(bus_s[0]), .imc_bus_b(bus_s[1]), .imc_bus_c(bus_s[2]), .la_bus_d(bus_s[3]));
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		expq.push_back(e);
		@(negedge mclk);
		reg_rd = 1'b0;
	endtask : rd
	task automatic results();
		$display("errors=%0d compares=%0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : results
	// ****************************************
	// watcher and timeout
	// ****************************************
	always @(posedge mclk) rd_seen <= reg_rd;
	always @(negedge mclk) begin
		if (rd_seen && expq.size() > 0) chk(reg_rdata, expq.pop_front());
	end
	// whole run is a few hundred cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			results();
		end
	end
	// ****************************************
	// stimulus
	// ****************************************
	initial begin
		foreach (sel[p]) begin
			sel[p] = 8'h00;
			lav[p] = 8'h00;
			lao[p] = 8'h00;
			ext[p] = 8'h5a;
		end
		lao[2] = 8'h04;
		repeat (5) @(negedge mclk);
		arst_n = 1'b1;
		repeat (2) @(negedge mclk);
		for (int p = 0; p < 4; p++) begin
			chk(poe[p], lao[p] & msk[p]);
			chk(po[p], 8'h00);
			rd(ofs_out[p], 8'h00);
			rd(ofs_dir[p], 8'h00);
		end
		lao[2] = 8'h00;
		rd(8'h20, 8'h00);
		wr(`PPIO_OFS_C_IN, 8'hff);
		rd(`PPIO_OFS_C_OUT, 8'h00);
		for (int k = 0; k < 6; k++) begin
			for (int p = 0; p < 4; p++) begin
				sel[p] = $random(seed) & $random(seed);
				lav[p] = $random(seed);
				lao[p] = $random(seed) & $random(seed);
				ext[p] = $random(seed);
				dir[p] = $random(seed);
				outr[p] = $random(seed);
				wr(ofs_dir[p], dir[p]);
				wr(ofs_out[p], outr[p]);
			end
			repeat (3) @(negedge mclk);
			for (int p = 0; p < 4; p++) begin
				eoe = (lao[p] | dir[p]) & msk[p];
				eout = ((sel[p] & lav[p]) | (~sel[p] & outr[p])) & msk[p];
				lvl = ((eoe & eout) | (~eoe & ext[p])) & msk[p];
				chk(poe[p], eoe);
				chk(po[p], eout);
				chk(bus[p], lvl);
				rd(ofs_in[p], lvl);
				rd(ofs_out[p], outr[p] & msk[p]);
				rd(ofs_dir[p], dir[p] & msk[p]);
			end
			chk(poe_s[0], 8'h00);
			chk(bus_s[0], 8'h00);
			chk(poe_s[3], (lao[3] | dir[3]) & `PPIO_MASK_D_SMALL);
			chk(po_s[1], po[1]);
		end
		wr(`PPIO_OFS_D_DIR, 8'hff);
		rd(`PPIO_OFS_D_DIR, `PPIO_MASK_D);
		chk(rdata_s, `PPIO_MASK_D_SMALL);
		repeat (2) @(negedge mclk);
		results();
	end
endmodule : tb_top
